// ---- design/bsit_pkg.sv ----
// Constants and carriers of the bit-stream input time tagger
package bsit_pkg;
    localparam int unsigned NSTR      = 32;
    localparam logic [7:0]  OFS_CTRL  = 8'h00;
    localparam logic [7:0]  OFS_MASK  = 8'h04;
    localparam logic [7:0]  OFS_LOAD  = 8'h08;
    localparam logic [7:0]  OFS_CMD   = 8'h0C;
    localparam logic [7:0]  OFS_STAT  = 8'h10;
    localparam logic [7:0]  OFS_SNAP  = 8'h14;
    localparam logic [7:0]  OFS_TEXT  = 8'h18;
    localparam logic [7:0]  OFS_SCYC  = 8'h1C;
    localparam logic [7:0]  OFS_BAUD  = 8'h20;
    localparam int unsigned CTRL_RUN  = 0;
    localparam int unsigned CTRL_ALT  = 1;
    localparam int unsigned CTRL_RATE = 4;
    localparam int unsigned RATE_W    = 3;
    localparam int unsigned CMD_ARM   = 0;
    localparam int unsigned ST_SET    = 0;
    localparam int unsigned ST_MERR   = 1;
    localparam int unsigned ST_OVF    = 2;
    localparam int unsigned ST_TVLD   = 3;
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] MASK_RST  = 32'hFFFF_FFFF;
    localparam logic [31:0] LOAD_RST  = 32'h0000_0000;
    localparam longint      SYS_HZ    = 250_000_000;
    localparam longint      STREAM_HZ = 32_000_000;
    localparam longint      TEXT_BAUD = 115_200;
    localparam logic [31:0] SCYC_RST  = 32'(STREAM_HZ);
    localparam logic [15:0] BAUD_RST  = 16'(SYS_HZ / TEXT_BAUD);
    localparam logic [11:0] TEXT_MAX  = 12'h800;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bsit_bus_s;

    typedef struct packed {
        logic [NSTR-1:0] data;
        logic            valid;
        logic            top;
        logic            flag;
        logic [31:0]     sec;
        logic [31:0]     cyc;
    } bsit_smp_s;

    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} bsit_rx_e;
endpackage : bsit_pkg

// ---- design/bsit_top.sv ----
// Bit-stream input time tagger: sampling, observe clock, register port
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// How it works
// R1: All 32 streams sampled together at one selectable common rate.
// R2: Active set must hold 1, 2, 4, 8, 16 or 32 streams.
// R3: Inactive streams are neither captured nor delivered; the code captures all 32 and forces their SAMPLE.data bits to 0.
// R4: Stream clock may also run at 64 or 128 MHz.
// R5: Stream clock is the reference; it is at least the stream rate.
// R6: Second tick marks the bits tagged on the integer second.
// R7: Acquisition side raises the tick with the top-of-second bit.
// R8: Validity input carried alongside, never interpreted.
// R9: Aux serial text received, at most 2048 bytes per second.
// R10: One time tag covers every stream of a sample.
// R11: Streams share one clock, one tick and one rate.
// R12: Slower rates sample on a divided enable aligned to the tick.
// R13: Armed load on next tick, then pure cycle counting.
// R14: Alternate asynchronous tick selectable instead of the normal one.
// R15: Monitor output pulses on each observe-clock second.
module bsit_top #(
    parameter logic [31:0] SEC_CYC = bsit_pkg::SCYC_RST
) (
    input  wire logic                    CLK_SYS,
    input  wire logic                    SYS_RST,
    input  wire bsit_pkg::bsit_bus_s     BUS,
    output logic [31:0]                  RDATA,
    input  wire logic                    STREAM_CLK,
    input  wire logic [bsit_pkg::NSTR-1:0] STREAM_IN,
    input  wire logic                    TICK_IN,
    input  wire logic                    ALT_TICK_IN,
    input  wire logic                    VALID_IN,
    input  wire logic                    TEXT_IN,
    output bsit_pkg::bsit_smp_s          SAMPLE,
    output logic                         TICK_MON
);
    import bsit_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [31:0]  ctrl_reg;
    logic [31:0]  mask_reg;
    logic [31:0]  load_reg;
    logic [31:0]  scyc_reg;
    logic [15:0]  baud_reg;
    logic         cfg_t_reg;
    logic         arm_t_reg;
    logic         merr_reg;
    logic         ovf_reg;
    logic         tvld_reg;
    logic [7:0]   text_reg;
    logic [31:0]  snap_reg;
    logic [31:0]  rdata_reg;
    logic [2:0]   lm_reg;
    logic [2:0]   ls_reg;
    logic [2:0]   ld_reg;
    logic [5:0]   ones;
    logic         mask_ok;
    logic         wr_mask;
    logic         wr_stat;
    logic         lset_reg;
    logic         ltick_t_reg;
    logic         lsnap_t_reg;
    logic [31:0]  lsnap_reg;

    assign ones    = 6'($countones(BUS.wdata));
    assign mask_ok = (ones != 6'h00) && ((ones & (ones - 6'h01)) == 6'h00);
    assign wr_mask = BUS.wr && (BUS.addr == OFS_MASK);
    assign wr_stat = BUS.wr && (BUS.addr == OFS_STAT);
    assign RDATA   = rdata_reg;

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            ctrl_reg  <= CTRL_RST;
            mask_reg  <= MASK_RST;
            load_reg  <= LOAD_RST;
            scyc_reg  <= SEC_CYC;
            baud_reg  <= BAUD_RST;
            cfg_t_reg <= 1'b0;
            arm_t_reg <= 1'b0;
        end
        else if (BUS.wr)
        begin
            if (BUS.addr == OFS_CTRL)
                ctrl_reg <= BUS.wdata;
            // Illegal set sizes are refused, old set stays
            if (wr_mask && mask_ok)
                mask_reg <= BUS.wdata; // R2
            if (BUS.addr == OFS_LOAD)
                load_reg <= BUS.wdata;
            if (BUS.addr == OFS_SCYC)
                scyc_reg <= BUS.wdata;
            if (BUS.addr == OFS_BAUD)
                baud_reg <= BUS.wdata[15:0];
            if (BUS.addr inside {OFS_CTRL, OFS_MASK, OFS_LOAD, OFS_SCYC})
                cfg_t_reg <= ~cfg_t_reg;
            if (BUS.addr == OFS_CMD && BUS.wdata[CMD_ARM])
                arm_t_reg <= ~arm_t_reg; // R13
        end
    end

    // Link-side toggles and level: snapshot, tick, time set
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            lm_reg <= 3'h0;
            ls_reg <= 3'h0;
            ld_reg <= 3'h0;
        end
        else
        begin
            lm_reg <= {lset_reg, ltick_t_reg, lsnap_t_reg};
            ls_reg <= lm_reg;
            ld_reg <= ls_reg;
        end
    end

    // Snapshot word holds a whole second, so the toggle is safe
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
            snap_reg <= 32'h0000_0000;
        else if (ls_reg[0] ^ ld_reg[0])
            snap_reg <= lsnap_reg; // R15
    end

    ////////////////////////////////////////////////////////////////////////
    logic [1:0]   tx_reg;
    bsit_rx_e     rx_reg;
    logic [15:0]  bcnt_reg;
    logic [2:0]   bidx_reg;
    logic [7:0]   shf_reg;
    logic [11:0]  tcnt_reg;
    logic         rx_done;

    assign rx_done = (rx_reg == RX_STOP) && (bcnt_reg == 16'h0000)
                     && tx_reg[1];

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            tx_reg   <= 2'h3;
            rx_reg   <= RX_IDLE;
            bcnt_reg <= 16'h0000;
            bidx_reg <= 3'h0;
            shf_reg  <= 8'h00;
        end
        else
        begin
            tx_reg   <= {tx_reg[0], TEXT_IN};
            bcnt_reg <= bcnt_reg - 16'h0001;
            unique case (rx_reg)
                RX_IDLE:
                    if (!tx_reg[1])
                    begin
                        rx_reg   <= RX_START;
                        bcnt_reg <= {1'b0, baud_reg[15:1]};
                    end
                RX_START:
                    if (bcnt_reg == 16'h0000)
                    begin
                        rx_reg   <= tx_reg[1] ? RX_IDLE : RX_DATA;
                        bcnt_reg <= baud_reg - 16'h0001;
                        bidx_reg <= 3'h0;
                    end
                RX_DATA:
                    if (bcnt_reg == 16'h0000)
                    begin
                        shf_reg  <= {tx_reg[1], shf_reg[7:1]};
                        bidx_reg <= bidx_reg + 3'h1;
                        bcnt_reg <= baud_reg - 16'h0001;
                        if (bidx_reg == 3'h7)
                            rx_reg <= RX_STOP;
                    end
                RX_STOP:
                    if (bcnt_reg == 16'h0000)
                        rx_reg <= RX_IDLE;
            endcase
        end
    end

    // Byte budget restarts on every second tick
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            tcnt_reg <= 12'h000;
            text_reg <= 8'h00;
            tvld_reg <= 1'b0;
            ovf_reg  <= 1'b0;
            merr_reg <= 1'b0;
        end
        else
        begin
            if (ls_reg[1] ^ ld_reg[1])
                tcnt_reg <= 12'h000; // R9
            else if (rx_done && tcnt_reg != TEXT_MAX)
                tcnt_reg <= tcnt_reg + 12'h001;
            if (rx_done && tcnt_reg != TEXT_MAX)
                text_reg <= shf_reg;
            // Set wins over the clear in all three flags
            tvld_reg <= (rx_done && tcnt_reg != TEXT_MAX)
                        || (tvld_reg
                            && !(BUS.rd && BUS.addr == OFS_TEXT));
            ovf_reg  <= (rx_done && tcnt_reg == TEXT_MAX)
                        || (ovf_reg && !(wr_stat && BUS.wdata[ST_OVF]));
            merr_reg <= (wr_mask && !mask_ok)
                        || (merr_reg && !(wr_stat && BUS.wdata[ST_MERR]));
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST || !BUS.rd)
            rdata_reg <= 32'h0000_0000;
        else
            unique case (BUS.addr)
                OFS_CTRL: rdata_reg <= ctrl_reg;
                OFS_MASK: rdata_reg <= mask_reg;
                OFS_LOAD: rdata_reg <= load_reg;
                OFS_STAT: rdata_reg <= {28'h000_0000, tvld_reg, ovf_reg,
                                        merr_reg, ls_reg[2]};
                OFS_SNAP: rdata_reg <= snap_reg;
                OFS_TEXT: rdata_reg <= {24'h00_0000, text_reg};
                OFS_SCYC: rdata_reg <= scyc_reg;
                OFS_BAUD: rdata_reg <= {16'h0000, baud_reg};
                default:  rdata_reg <= 32'h0000_0000;
            endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Stream clock domain: any rate up to 128 MHz works here // R4 R5
    logic [1:0]        lr_reg;
    logic [NSTR+2:0]   pm_reg;
    logic [NSTR+2:0]   ps_reg;
    logic              tp_reg;
    logic [1:0]        cm_reg;
    logic [1:0]        cs_reg;
    logic [1:0]        cd_reg;
    logic [NSTR-1:0]   lmask_reg;
    logic [RATE_W-1:0] lrate_reg;
    logic              lrun_reg;
    logic              lalt_reg;
    logic [31:0]       lload_reg;
    logic [31:0]       lscyc_reg;
    logic              arm_reg;
    logic [31:0]       sec_reg;
    logic [31:0]       cyc_reg;
    logic [5:0]        div_reg;
    logic              lrst;
    logic              tick_lvl;
    logic              tick_ev;
    logic              load;
    logic              timed;
    logic [31:0]       now_sec;
    logic [31:0]       now_cyc;
    logic              wrap;
    logic [5:0]        div_max;
    logic [5:0]        div_base;
    logic              ce;

    assign lrst     = lr_reg[1];
    // Edge of the chosen tick; partner raises it with the top bit // R7 R11
    assign tick_lvl = lalt_reg ? ps_reg[NSTR+2] : ps_reg[NSTR]; // R14
    assign tick_ev  = tick_lvl && !tp_reg; // R6
    assign load     = arm_reg && tick_ev; // R13
    assign timed    = lset_reg || load;
    assign now_sec  = load ? lload_reg : sec_reg;
    assign now_cyc  = load ? 32'h0000_0000 : cyc_reg;
    assign wrap     = now_cyc == (lscyc_reg - 32'h0000_0001);
    assign div_max  = 6'((7'h01 << lrate_reg) - 7'h01);
    assign div_base = tick_ev ? 6'h00 : div_reg;
    assign ce       = div_base == 6'h00; // R12

    always_ff @(posedge STREAM_CLK)
    begin
        lr_reg <= {lr_reg[0], SYS_RST};
        pm_reg <= {ALT_TICK_IN, VALID_IN, TICK_IN, STREAM_IN};
        ps_reg <= pm_reg;
        tp_reg <= tick_lvl;
    end

    // Config words stay still while their toggle crosses
    always_ff @(posedge STREAM_CLK)
    begin
        if (lrst)
        begin
            cm_reg    <= 2'h0;
            cs_reg    <= 2'h0;
            cd_reg    <= 2'h0;
            lmask_reg <= MASK_RST;
            lrate_reg <= CTRL_RST[CTRL_RATE +: RATE_W];
            lrun_reg  <= CTRL_RST[CTRL_RUN];
            lalt_reg  <= CTRL_RST[CTRL_ALT];
            lload_reg <= LOAD_RST;
            lscyc_reg <= SEC_CYC;
        end
        else
        begin
            cm_reg <= {arm_t_reg, cfg_t_reg};
            cs_reg <= cm_reg;
            cd_reg <= cs_reg;
            if (cs_reg[0] ^ cd_reg[0])
            begin
                lmask_reg <= mask_reg;
                lrate_reg <= ctrl_reg[CTRL_RATE +: RATE_W];
                lrun_reg  <= ctrl_reg[CTRL_RUN];
                lalt_reg  <= ctrl_reg[CTRL_ALT];
                lload_reg <= load_reg;
                lscyc_reg <= scyc_reg;
            end
        end
    end

    // Observe clock: later ticks are ignored unless armed again
    always_ff @(posedge STREAM_CLK)
    begin
        if (lrst)
        begin
            arm_reg     <= 1'b0;
            lset_reg    <= 1'b0;
            sec_reg     <= 32'h0000_0000;
            cyc_reg     <= 32'h0000_0000;
            div_reg     <= 6'h00;
            ltick_t_reg <= 1'b0;
            lsnap_t_reg <= 1'b0;
            lsnap_reg   <= 32'h0000_0000;
        end
        else
        begin
            arm_reg  <= (cs_reg[1] ^ cd_reg[1]) || (arm_reg && !tick_ev);
            lset_reg <= timed;
            div_reg  <= (div_base == div_max) ? 6'h00 : div_base + 6'h01;
            if (tick_ev)
                ltick_t_reg <= ~ltick_t_reg;
            if (timed)
            begin
                sec_reg <= wrap ? now_sec + 32'h0000_0001 : now_sec; // R13
                cyc_reg <= wrap ? 32'h0000_0000 : now_cyc + 32'h0000_0001;
            end
            if (timed && now_cyc == 32'h0000_0000)
            begin
                lsnap_reg   <= now_sec;
                lsnap_t_reg <= ~lsnap_t_reg;
            end
        end
    end

    // One tag per sample word shared by every stream // R10
    always_ff @(posedge STREAM_CLK)
    begin
        if (lrst)
        begin
            SAMPLE   <= '0;
            TICK_MON <= 1'b0;
        end
        else
        begin
            SAMPLE.valid <= ce && lrun_reg && timed; // R1
            SAMPLE.data  <= ps_reg[NSTR-1:0] & lmask_reg; // R3
            SAMPLE.flag  <= ps_reg[NSTR+1]; // R8
            SAMPLE.top   <= timed && now_cyc == 32'h0000_0000;
            SAMPLE.sec   <= now_sec;
            SAMPLE.cyc   <= now_cyc;
            TICK_MON     <= timed && now_cyc == 32'h0000_0000; // R15
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_mask_keep;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        wr_mask && !mask_ok |=> $stable(mask_reg) && merr_reg;
    endproperty
    a_mask_keep: assert property (p_mask_keep) // R2
        else $error("illegal stream set was accepted");

    property p_text_cap;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        rx_done && tcnt_reg == TEXT_MAX && !(ls_reg[1] ^ ld_reg[1])
        |=> ovf_reg && $stable(text_reg) && tcnt_reg == TEXT_MAX;
    endproperty
    a_text_cap: assert property (p_text_cap) // R9
        else $error("text byte beyond budget not refused");

    property p_inactive;
        @(posedge STREAM_CLK) disable iff (lrst)
        SAMPLE.valid |-> (SAMPLE.data & ~$past(lmask_reg)) == '0;
    endproperty
    a_inactive: assert property (p_inactive) // R3
        else $error("inactive stream delivered");

    property p_rate;
        @(posedge STREAM_CLK) disable iff (lrst)
        tick_ev && lrun_reg && timed && div_max != 6'h00
        |=> SAMPLE.valid ##1 !SAMPLE.valid;
    endproperty
    a_rate: assert property (p_rate) // R12
        else $error("divided sampling not aligned to tick");

    property p_load;
        @(posedge STREAM_CLK) disable iff (lrst)
        arm_reg && tick_ev
        |=> SAMPLE.top && SAMPLE.cyc == 32'h0000_0000
            && SAMPLE.sec == $past(lload_reg) && !arm_reg;
    endproperty
    a_load: assert property (p_load) // R13
        else $error("observe clock not loaded on armed tick");

    property p_count;
        @(posedge STREAM_CLK) disable iff (lrst)
        lset_reg && !arm_reg && !wrap
        |=> cyc_reg == $past(cyc_reg) + 32'h0000_0001
            && sec_reg == $past(sec_reg);
    endproperty
    a_count: assert property (p_count) // R13
        else $error("observe clock disturbed while free running");

    property p_alt;
        @(posedge STREAM_CLK) disable iff (lrst)
        lalt_reg && $past(lalt_reg) && arm_reg
        && ps_reg[NSTR+2] && !$past(ps_reg[NSTR+2])
        |=> SAMPLE.top && SAMPLE.sec == $past(lload_reg);
    endproperty
    a_alt: assert property (p_alt) // R14
        else $error("alternate tick edge missed");

    property p_flag;
        @(posedge STREAM_CLK) disable iff (lrst)
        1'b1 |=> SAMPLE.flag == $past(ps_reg[NSTR+1]);
    endproperty
    a_flag: assert property (p_flag) // R8
        else $error("validity not carried through");

    property p_mon;
        @(posedge STREAM_CLK) disable iff (lrst)
        lset_reg && wrap
        |-> ##2 TICK_MON && SAMPLE.top && SAMPLE.cyc == 32'h0000_0000;
    endproperty
    a_mon: assert property (p_mon) // R15
        else $error("monitor pulse off the observe second");
endmodule : bsit_top

// ---- testbench/bsit_acq_model.sv ----
// Acquisition-side model: streams, validity, ticks and serial text
`timescale 1ns/1ps
module bsit_acq_model #(
    parameter int BIT_NS = 64
) (
    input  wire logic   clk,
    output logic [31:0] stream_o,
    output logic        tick_o,
    output logic        alt_tick_o,
    output logic        valid_o,
    output logic        text_o
);
    integer seed = 29395;

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        stream_o   = 32'h0000_0000;
        tick_o     = 1'b0;
        alt_tick_o = 1'b0;
        valid_o    = 1'b0;
        text_o     = 1'b1;
    end

    // Every stream shares this clock and changes at one rate
    always @(posedge clk)
    begin
        stream_o <= 32'($random(seed));
        valid_o  <= 1'($random(seed));
    end

    ////////////////////////////////////////////////////////////////////////
    // Tick rises with the top-of-second bit; held a few cycles
    task automatic fire_tick(input logic alt);
        @(posedge clk);
        tick_o     <= !alt;
        alt_tick_o <= alt;
        repeat (4) @(posedge clk);
        tick_o     <= 1'b0;
        alt_tick_o <= 1'b0;
    endtask : fire_tick

    // Start, eight data bits first bit lowest, stop; idle stays high
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            text_o <= frame[i];
            #(BIT_NS);
        end
    endtask : send_byte
endmodule : bsit_acq_model

// ---- testbench/bsit_top_bench.sv ----
// Self-checking bench for the bit-stream input time tagger
`timescale 1ns/1ps
module bsit_top_bench;
    import bsit_pkg::*;
    localparam logic [31:0] SC = 32'h0000_0040;
    logic        clk_sys = 1'b0;
    logic        stream_clk = 1'b0;
    logic        sys_rst = 1'b1;
    bsit_bus_s   bus = '0;
    logic [31:0] rdata;
    logic [31:0] stream;
    logic        tick;
    logic        alt_tick;
    logic        valid_in;
    logic        text;
    bsit_smp_s   smp;
    logic        tick_mon;
    int          err_total = 0;
    int          total_checks = 0;
    logic [33:0] h [0:4];
    logic [31:0] m_mask = 32'hFFFF_FFFF;
    logic [31:0] m_load;
    logic [31:0] m_sec;
    logic [31:0] m_cyc;
    logic [31:0] rd_v;
    logic [63:0] mm;
    logic [7:0]  tb;
    logic [7:0]  ra [0:6];
    logic [31:0] rv [0:6];
    int          m_step = 1;
    logic        m_alt = 1'b0;
    logic        m_arm = 1'b0;
    logic        m_set = 1'b0;
    logic        m_pre = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    always #2 clk_sys = ~clk_sys;
    // Odd offset keeps the two clocks out of step
    initial
    begin
        #1.3;
        forever #6 stream_clk = ~stream_clk;
    end

    bsit_top #(
        .SEC_CYC (SC)
    ) bsit_top_i (
        .CLK_SYS     (clk_sys),
        .SYS_RST     (sys_rst),
        .BUS         (bus),
        .RDATA       (rdata),
        .STREAM_CLK  (stream_clk),
        .STREAM_IN   (stream),
        .TICK_IN     (tick),
        .ALT_TICK_IN (alt_tick),
        .VALID_IN    (valid_in),
        .TEXT_IN     (text),
        .SAMPLE      (smp),
        .TICK_MON    (tick_mon)
    );

    bsit_acq_model #(
        .BIT_NS (64)
    ) bsit_acq_model_i (
        .clk        (stream_clk),
        .stream_o   (stream),
        .tick_o     (tick),
        .alt_tick_o (alt_tick),
        .valid_o    (valid_in),
        .text_o     (text)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Gap after each write lets config settle in the link domain
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
        repeat (24) @(posedge clk_sys);
    endtask : wreg

    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rreg

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////
    // Reference observe clock; pins reach SAMPLE three edges later
    always @(negedge stream_clk)
    begin
        for (int i = 4; i > 0; i--)
            h[i] = h[i-1];
        h[0] = {m_alt ? alt_tick : tick, valid_in, stream};
        if (m_set)
            m_cyc = m_cyc + 1;
        if (m_set && m_cyc == SC)
        begin
            m_cyc = 0;
            m_sec = m_sec + 1;
        end
        if (m_arm && h[3][33] && !h[4][33])
        begin
            m_arm = 1'b0;
            m_set = 1'b1;
            m_sec = m_load;
            m_cyc = 0;
        end
        if (m_pre)
            chk("early valid", 32'(smp.valid), 0);
        if (m_set)
        begin
            chk("valid", 32'(smp.valid), 32'(m_cyc % m_step == 0));
            chk("monitor", 32'(tick_mon), 32'(m_cyc == 0));
        end
        if (m_set && smp.valid === 1'b1)
        begin
            chk("data", smp.data, h[3][31:0] & m_mask);
            chk("flag", 32'(smp.flag), 32'(h[3][32]));
            chk("top", 32'(smp.top), 32'(m_cyc == 0));
            chk("sec", smp.sec, m_sec);
            chk("cyc", smp.cyc, m_cyc);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        ra = '{OFS_CTRL, OFS_MASK, OFS_LOAD, OFS_SCYC, OFS_BAUD, OFS_STAT,
               8'h24};
        rv = '{CTRL_RST, MASK_RST, LOAD_RST, SC, {16'h0000, BAUD_RST},
               32'h0000_0000, 32'h0000_0000};
        repeat (5) @(posedge stream_clk);
        // Link reset has reached the sample outputs by now
        m_pre = 1'b1;
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (4) @(posedge stream_clk);
        for (int i = 0; i < 7; i++)
        begin
            rreg(ra[i], rd_v);
            chk("reset value", rd_v, rv[i]);
        end
        wreg(OFS_BAUD, 32'h0000_0010);
        wreg(OFS_CTRL, 32'h0000_0001);
        repeat (20) @(posedge stream_clk);
        m_pre = 1'b0;
        // Rate codes 0 to 6 once each, active sets of every legal size
        for (int s = 0; s < 7; s++)
        begin
            m_set = 1'b0;
            m_alt = (s == 3);
            m_step = 1 << s;
            mm = ((64'd1 << (1 << (s % 6))) - 1) << (s * 7 % 32);
            m_mask = mm[31:0] | mm[63:32];
            m_load = 32'h0000_1000 + 32'(s);
            wreg(OFS_CTRL, {25'h0, 3'(s), 2'b00, m_alt, 1'b1});
            wreg(OFS_MASK, m_mask);
            wreg(OFS_LOAD, m_load);
            wreg(OFS_CMD, 32'h0000_0001);
            m_arm = 1'b1;
            bsit_acq_model_i.fire_tick(m_alt);
            repeat (100) @(posedge stream_clk);
            // A later tick must not move the running clock
            if (s == 0)
                bsit_acq_model_i.fire_tick(1'b0);
            repeat (60) @(posedge stream_clk);
            rreg(OFS_STAT, rd_v);
            chk("time set", 32'(rd_v[ST_SET]), 1);
            for (int k = 0; k < 80 && m_cyc != 32; k++)
                @(posedge stream_clk);
            rreg(OFS_SNAP, rd_v);
            chk("snapshot", rd_v, m_sec);
        end
        // Illegal active set of three streams is refused
        wreg(OFS_MASK, 32'h0000_0007);
        rreg(OFS_MASK, rd_v);
        chk("mask kept", rd_v, m_mask);
        rreg(OFS_STAT, rd_v);
        chk("mask error", 32'(rd_v[ST_MERR]), 1);
        wreg(OFS_STAT, 32'h0000_0002);
        rreg(OFS_STAT, rd_v);
        chk("error cleared", 32'(rd_v[ST_MERR]), 0);
        for (int t = 0; t < 2; t++)
        begin
            tb = t ? 8'hC5 : 8'h41;
            bsit_acq_model_i.send_byte(tb);
            rd_v = 32'h0000_0000;
            for (int k = 0; k < 20 && rd_v[ST_TVLD] !== 1'b1; k++)
                rreg(OFS_STAT, rd_v);
            rreg(OFS_TEXT, rd_v);
            chk("text byte", rd_v, {24'h0, tb});
            rreg(OFS_STAT, rd_v);
            chk("text taken", 32'(rd_v[ST_TVLD]), 0);
        end
        test_done;
    end

    // Whole run needs about 25 us
    initial
    begin
        #200_000;
        err_total++;
        test_done;
    end
endmodule : bsit_top_bench
